// ### design/port_gate_select.sv
/*
  per-port gate selection: picks the enable set for the present power mode while auto_gate is set, else the run set.
  assumes registered inputs from the register file in the same clock domain.
*/
`timescale 1ns/100ps
`include "sleep_gate_params.svh"

module port_gate_select #(
  parameter int NUM_PORTS = `SG_NUM_PORTS
) (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire sleep_gate_pkg::power_mode_t mode,
  input  wire logic                       auto_gate,
  input  wire logic [NUM_PORTS-1:0]       run_gate,
  input  wire logic [NUM_PORTS-1:0]       sleep_gate,
  input  wire logic [NUM_PORTS-1:0]       deep_gate,
  output      logic [NUM_PORTS-1:0]       port_en
);
  import sleep_gate_pkg::*;

  logic [NUM_PORTS-1:0] next_port_en;

  // one selector per port
  for (genvar i = 0; i < NUM_PORTS; i++) begin : g_port
    always_comb begin
      next_port_en[i] = run_gate[i];
      if (auto_gate) begin
        if (mode == mode_sleep) begin
          next_port_en[i] = sleep_gate[i];
        end else if (mode == mode_deep_sleep) begin
          next_port_en[i] = deep_gate[i];
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      port_en <= '0;
    end else begin
      port_en <= next_port_en;
    end
  end

  a_sleep_select: assert property (@(posedge core_clk) disable iff (rst)
    (auto_gate && mode == mode_sleep) |=> port_en == $past(sleep_gate))
    else $error("sleep gate not applied in sleep");
  a_no_auto_run: assert property (@(posedge core_clk) disable iff (rst)
    !auto_gate |=> port_en == $past(run_gate))
    else $error("run gate not kept without auto gating");
endmodule // port_gate_select

// ### design/sleep_gate_params.svh
/*
  offsets, field positions, reset values and counts for the port clock gate block.
  assumes inclusion by bare name from design and bench files.
*/
`ifndef SLEEP_GATE_PARAMS_SVH
`define SLEEP_GATE_PARAMS_SVH

`define SG_NUM_PORTS         5
`define SG_OFF_RUN_GATE      12'h108
`define SG_OFF_SLEEP_GATE    12'h118
`define SG_OFF_DEEP_GATE     12'h128
`define SG_OFF_RUN_CFG       12'h060
`define SG_OFF_IRQ_STATUS    12'h200
`define SG_OFF_IRQ_MASK      12'h204
`define SG_OFF_POWER_STATE   12'h208
`define SG_BIT_AUTO_GATE     11
`define SG_GATE_RESET        32'h00000000
`define SG_CFG_RESET         32'h00000000
`define SG_IRQ_FAULT_BIT     0
`define SG_IRQ_SLEEP_BIT     1
`define SG_IRQ_WAKE_BIT      2
`define SG_IRQ_WIDTH         3

`endif

// ### design/sleep_gate_pkg.sv
/*
  types for the port clock gate block.
  assumes nothing of its surroundings.
*/
package sleep_gate_pkg;
  typedef enum logic [1:0] {
    mode_run,
    mode_sleep,
    mode_deep_sleep
  } power_mode_t;
endpackage

// ### design/sleep_port_clock_gating.sv
/*
  port clock gating control with apb register slave, per-port clock enables
  and bus fault detection for accesses to gated ports.
  assumes apb master on core_clk; sleep and deep_sleep levels synchronous.
*/
// Notes on behaviour
// - each enable bit lets its port run when one and stops and disables it when zero.
// - an access to a port whose clock is gated off gets a bus fault instead of completing.
// - all gating enable bits are zero after reset, so every port starts unclocked.
// - bits 4 down to 0 gate the fifth down to the first port in order.
// - bits 31 to 5 read zero and ignore writes; software keeps them across read-modify-write.
// - run gating applies while running, sleep gating in sleep, deep-sleep gating in deep sleep.
// - sleep and deep-sleep gating act only while the automatic gate select bit is set.
`timescale 1ns/100ps
`include "sleep_gate_params.svh"

module sleep_port_clock_gating #(
  parameter int NUM_PORTS = `SG_NUM_PORTS
) (
  input  wire logic                        core_clk,
  input  wire logic                        rst,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output      logic [31:0]                 prdata,
  output      logic                        pready,
  output      logic                        pslverr,
  input  wire logic                        sleep_req,
  input  wire logic                        deep_sleep_req,
  input  wire logic                        port_access,
  input  wire logic [2:0]                  port_access_sel,
  output      logic                        port_bus_fault,
  output      logic [NUM_PORTS-1:0]        port_clock_en,
  output      logic                        irq
);
  import sleep_gate_pkg::*;

  // port index is three bits wide, so at most eight ports
  if (NUM_PORTS < 1 || NUM_PORTS > 8) begin : g_bad_ports
    $error("NUM_PORTS must be 1 to 8");
  end

  // register state
  logic [NUM_PORTS-1:0]     run_port_clock_gate;
  logic [NUM_PORTS-1:0]     sleep_port_clock_gate;
  logic [NUM_PORTS-1:0]     deep_sleep_port_clock_gate;
  logic                     auto_clock_gate_select;
  logic [`SG_IRQ_WIDTH-1:0] irq_status;
  logic [`SG_IRQ_WIDTH-1:0] irq_mask;
  power_mode_t              mode;
  logic [NUM_PORTS-1:0]     next_run;
  logic [NUM_PORTS-1:0]     next_sleep;
  logic [NUM_PORTS-1:0]     next_deep;
  logic                     next_auto;
  logic [`SG_IRQ_WIDTH-1:0] next_status;
  logic [`SG_IRQ_WIDTH-1:0] next_mask;
  power_mode_t              next_mode;
  logic [31:0]              next_prdata;
  logic                     next_pready;
  logic                     next_pslverr;
  logic                     next_fault;
  logic                     next_irq;
  logic [NUM_PORTS-1:0]     gate_en;
  logic                     wr_acc;
  logic                     rd_acc;
  logic                     sel_valid;
  logic                     sel_gated;
  logic [`SG_IRQ_WIDTH-1:0] events;

  port_gate_select #(
    .NUM_PORTS (NUM_PORTS)
  ) u_select (
    .core_clk   (core_clk),
    .rst        (rst),
    .mode       (mode),
    .auto_gate  (auto_clock_gate_select),
    .run_gate   (run_port_clock_gate),
    .sleep_gate (sleep_port_clock_gate),
    .deep_gate  (deep_sleep_port_clock_gate),
    .port_en    (gate_en)
  );

  // apb: one-cycle setup then access phase answered one cycle later by registered pready
  assign wr_acc = psel && penable && !pready && pwrite;
  assign rd_acc = psel && penable && !pready && !pwrite;

  assign sel_valid = 32'(port_access_sel) < 32'(NUM_PORTS);
  assign sel_gated = port_access && (!sel_valid || !gate_en[port_access_sel[2:0]]);

  always_comb begin
    next_mode = mode_run;
    if (deep_sleep_req) begin
      next_mode = mode_deep_sleep;
    end else if (sleep_req) begin
      next_mode = mode_sleep;
    end
  end

  assign events[`SG_IRQ_FAULT_BIT] = sel_gated;
  assign events[`SG_IRQ_SLEEP_BIT] = next_mode != mode_run && mode == mode_run;
  assign events[`SG_IRQ_WAKE_BIT]  = next_mode == mode_run && mode != mode_run;

  always_comb begin
    next_run     = run_port_clock_gate;
    next_sleep   = sleep_port_clock_gate;
    next_deep    = deep_sleep_port_clock_gate;
    next_auto    = auto_clock_gate_select;
    next_mask    = irq_mask;
    next_status  = irq_status;
    next_prdata  = prdata;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    if (psel && penable && !pready) begin
      next_pready = 1'b1;
      next_prdata = 32'h00000000;
    end
    if (wr_acc) begin
      unique case (paddr)
        `SG_OFF_RUN_GATE:   next_run   = pwdata[NUM_PORTS-1:0];
        `SG_OFF_SLEEP_GATE: next_sleep = pwdata[NUM_PORTS-1:0];
        `SG_OFF_DEEP_GATE:  next_deep  = pwdata[NUM_PORTS-1:0];
        `SG_OFF_RUN_CFG:    next_auto  = pwdata[`SG_BIT_AUTO_GATE];
        `SG_OFF_IRQ_MASK:   next_mask  = pwdata[`SG_IRQ_WIDTH-1:0];
        `SG_OFF_IRQ_STATUS,
        `SG_OFF_POWER_STATE: ;
        default:            next_pslverr = 1'b1;
      endcase
    end
    if (rd_acc) begin
      unique case (paddr)
        `SG_OFF_RUN_GATE:   next_prdata[NUM_PORTS-1:0] = run_port_clock_gate;
        `SG_OFF_SLEEP_GATE: next_prdata[NUM_PORTS-1:0] = sleep_port_clock_gate;
        `SG_OFF_DEEP_GATE:  next_prdata[NUM_PORTS-1:0] = deep_sleep_port_clock_gate;
        `SG_OFF_RUN_CFG:    next_prdata[`SG_BIT_AUTO_GATE] = auto_clock_gate_select;
        `SG_OFF_IRQ_MASK:   next_prdata[`SG_IRQ_WIDTH-1:0] = irq_mask;
        `SG_OFF_IRQ_STATUS: begin
          next_prdata[`SG_IRQ_WIDTH-1:0] = irq_status;
          next_status = '0;
        end
        `SG_OFF_POWER_STATE: next_prdata[NUM_PORTS+1:0] = {2'(mode), gate_en};
        default:            next_pslverr = 1'b1;
      endcase
    end
    // set wins over read clear
    next_status = next_status | events;
    next_fault  = sel_gated;
    next_irq    = |(next_status & next_mask);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      run_port_clock_gate        <= NUM_PORTS'(`SG_GATE_RESET);
      sleep_port_clock_gate      <= NUM_PORTS'(`SG_GATE_RESET);
      deep_sleep_port_clock_gate <= NUM_PORTS'(`SG_GATE_RESET);
      auto_clock_gate_select     <= 1'b0;
      irq_status                 <= '0;
      irq_mask                   <= '0;
      mode                       <= mode_run;
      prdata                     <= 32'h00000000;
      pready                     <= 1'b0;
      pslverr                    <= 1'b0;
      port_bus_fault             <= 1'b0;
      port_clock_en              <= '0;
      irq                        <= 1'b0;
    end else begin
      run_port_clock_gate        <= next_run;
      sleep_port_clock_gate      <= next_sleep;
      deep_sleep_port_clock_gate <= next_deep;
      auto_clock_gate_select     <= next_auto;
      irq_status                 <= next_status;
      irq_mask                   <= next_mask;
      mode                       <= next_mode;
      prdata                     <= next_prdata;
      pready                     <= next_pready;
      pslverr                    <= next_pslverr;
      port_bus_fault             <= next_fault;
      port_clock_en              <= gate_en;
      irq                        <= next_irq;
    end
  end

  // port fault checks
  a_fault_on_gated: assert property (@(posedge core_clk) disable iff (rst)
    (port_access && {1'b0, port_access_sel} < 4'(NUM_PORTS) && !gate_en[port_access_sel])
    |=> port_bus_fault)
    else $error("no bus fault for gated port access");

  a_no_fault_open: assert property (@(posedge core_clk) disable iff (rst)
    (port_access && {1'b0, port_access_sel} < 4'(NUM_PORTS) && gate_en[port_access_sel])
    |=> !port_bus_fault)
    else $error("bus fault on clocked port");

  a_fault_cleared: assert property (@(posedge core_clk) disable iff (rst)
    !port_access |=> !port_bus_fault)
    else $error("bus fault without port access");

  // reset state
  a_reset_zero: assert property (@(posedge core_clk)
    rst |=> (sleep_port_clock_gate == '0 && port_clock_en == '0))
    else $error("gate not zero after reset");

  a_reset_all: assert property (@(posedge core_clk)
    rst |=> (run_port_clock_gate == '0 && deep_sleep_port_clock_gate == '0 && gate_en == '0))
    else $error("gating state not zero after reset");

  a_reset_outputs: assert property (@(posedge core_clk)
    rst |=> (!pready && !pslverr && !port_bus_fault && !irq && prdata == '0))
    else $error("outputs not idle after reset");

  // clock enable pipe, register writes and reads
  a_clock_en_pipe: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |=> port_clock_en == $past(gate_en))
    else $error("port clock enable does not follow selection");

  a_sleep_write: assert property (@(posedge core_clk) disable iff (rst)
    (wr_acc && paddr == `SG_OFF_SLEEP_GATE)
    |=> sleep_port_clock_gate == $past(pwdata[NUM_PORTS-1:0]))
    else $error("sleep gate write lost");

  a_run_write: assert property (@(posedge core_clk) disable iff (rst)
    (wr_acc && paddr == `SG_OFF_RUN_GATE)
    |=> run_port_clock_gate == $past(pwdata[NUM_PORTS-1:0]))
    else $error("run gate write lost");

  a_deep_write: assert property (@(posedge core_clk) disable iff (rst)
    (wr_acc && paddr == `SG_OFF_DEEP_GATE)
    |=> deep_sleep_port_clock_gate == $past(pwdata[NUM_PORTS-1:0]))
    else $error("deep sleep gate write lost");

  a_sleep_hold: assert property (@(posedge core_clk) disable iff (rst)
    !(wr_acc && paddr == `SG_OFF_SLEEP_GATE) |=> $stable(sleep_port_clock_gate))
    else $error("sleep gate changed without a write");

  a_sleep_read: assert property (@(posedge core_clk) disable iff (rst)
    (rd_acc && paddr == `SG_OFF_SLEEP_GATE)
    |=> prdata[NUM_PORTS-1:0] == $past(sleep_port_clock_gate))
    else $error("sleep gate read wrong");

  a_reserved_zero: assert property (@(posedge core_clk) disable iff (rst)
    (rd_acc && (paddr == `SG_OFF_SLEEP_GATE || paddr == `SG_OFF_RUN_GATE
      || paddr == `SG_OFF_DEEP_GATE)) |=> prdata[31:NUM_PORTS] == '0)
    else $error("reserved bits read nonzero");

  // mode selection
  a_clock_follow: assert property (@(posedge core_clk) disable iff (rst)
    (auto_clock_gate_select && mode == mode_sleep && $stable(sleep_port_clock_gate))
    ##1 $stable(mode) && $stable(auto_clock_gate_select)
    |=> port_clock_en == $past(sleep_port_clock_gate, 2))
    else $error("port clocks do not follow sleep gate");

  a_deep_select: assert property (@(posedge core_clk) disable iff (rst)
    (auto_clock_gate_select && mode == mode_deep_sleep)
    |=> gate_en == $past(deep_sleep_port_clock_gate))
    else $error("deep sleep gate not applied");

  a_run_select: assert property (@(posedge core_clk) disable iff (rst)
    (mode == mode_run) |=> gate_en == $past(run_port_clock_gate))
    else $error("run gate not applied while running");

  a_sleep_mode: assert property (@(posedge core_clk) disable iff (rst)
    (sleep_req && !deep_sleep_req) |=> mode == mode_sleep)
    else $error("sleep mode not entered");

  a_deep_wins: assert property (@(posedge core_clk) disable iff (rst)
    deep_sleep_req |=> mode == mode_deep_sleep)
    else $error("deep sleep mode not entered");

  a_auto_needed: assert property (@(posedge core_clk) disable iff (rst)
    (!auto_clock_gate_select && mode == mode_sleep)
    |=> gate_en == $past(run_port_clock_gate))
    else $error("sleep gate active without auto select");

  a_auto_write: assert property (@(posedge core_clk) disable iff (rst)
    (wr_acc && paddr == `SG_OFF_RUN_CFG)
    |=> auto_clock_gate_select == $past(pwdata[`SG_BIT_AUTO_GATE]))
    else $error("auto gate select write lost");

  a_power_read: assert property (@(posedge core_clk) disable iff (rst)
    (rd_acc && paddr == `SG_OFF_POWER_STATE)
    |=> (prdata[NUM_PORTS-1:0] == $past(gate_en)
      && prdata[NUM_PORTS+1:NUM_PORTS] == $past(mode)
      && prdata[31:NUM_PORTS+2] == '0))
    else $error("power state read wrong");

  // bus answer
  a_apb_answer: assert property (@(posedge core_clk) disable iff (rst)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("apb answer not one cycle");

  a_pslverr_unmapped: assert property (@(posedge core_clk) disable iff (rst)
    (psel && penable && !pready && !(paddr inside {`SG_OFF_RUN_GATE, `SG_OFF_SLEEP_GATE,
      `SG_OFF_DEEP_GATE, `SG_OFF_RUN_CFG, `SG_OFF_IRQ_STATUS, `SG_OFF_IRQ_MASK,
      `SG_OFF_POWER_STATE})) |=> (pready && pslverr))
    else $error("no error for unmapped address");

  a_pslverr_mapped: assert property (@(posedge core_clk) disable iff (rst)
    (psel && penable && !pready && (paddr inside {`SG_OFF_RUN_GATE, `SG_OFF_SLEEP_GATE,
      `SG_OFF_DEEP_GATE, `SG_OFF_RUN_CFG, `SG_OFF_IRQ_STATUS, `SG_OFF_IRQ_MASK,
      `SG_OFF_POWER_STATE})) |=> (pready && !pslverr))
    else $error("error on mapped address");

  a_pslverr_alone: assert property (@(posedge core_clk) disable iff (rst)
    pslverr |-> pready)
    else $error("error response without ready");

  // interrupt status
  a_mask_write: assert property (@(posedge core_clk) disable iff (rst)
    (wr_acc && paddr == `SG_OFF_IRQ_MASK)
    |=> irq_mask == $past(pwdata[`SG_IRQ_WIDTH-1:0]))
    else $error("interrupt mask write lost");

  a_status_clear: assert property (@(posedge core_clk) disable iff (rst)
    (rd_acc && paddr == `SG_OFF_IRQ_STATUS && events == '0) |=> irq_status == '0)
    else $error("status not cleared by read");

  a_set_wins: assert property (@(posedge core_clk) disable iff (rst)
    (events != '0) |=> (irq_status & $past(events)) == $past(events))
    else $error("event lost in status");

  a_irq_level: assert property (@(posedge core_clk) disable iff (rst)
    irq == |(irq_status & irq_mask))
    else $error("interrupt level wrong");

  c_sleep_entry: cover property (@(posedge core_clk) disable iff (rst)
    auto_clock_gate_select && mode == mode_sleep && port_clock_en != '0);
  c_fault_seen: cover property (@(posedge core_clk) disable iff (rst) port_bus_fault);
  c_irq_raised: cover property (@(posedge core_clk) disable iff (rst) $rose(irq));
  c_deep_sleep: cover property (@(posedge core_clk) disable iff (rst)
    auto_clock_gate_select && mode == mode_deep_sleep);
  c_power_read: cover property (@(posedge core_clk) disable iff (rst)
    rd_acc && paddr == `SG_OFF_POWER_STATE && mode == mode_deep_sleep);
endmodule // sleep_port_clock_gating

// ### verif/sleep_port_clock_gating_tb_top.sv
/*
  self-checking bench for the port clock gate block: apb tasks, gating and fault sequences.
  assumes design files compiled first and design/ on the include path.
*/
`timescale 1ns/100ps
`include "sleep_gate_params.svh"

module sleep_port_clock_gating_tb_top;
  import sleep_gate_pkg::*;
  logic        core_clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        sleep_req;
  logic        deep_sleep_req;
  logic        port_access;
  logic [2:0]  port_access_sel;
  logic        port_bus_fault;
  logic [4:0]  port_clock_en;
  logic        irq;
  int          n_errors;
  int          comparisons;
  logic [31:0] rd_val;

  sleep_port_clock_gating DUT (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req), .port_access(port_access),
    .port_access_sel(port_access_sel), .port_bus_fault(port_bus_fault),
    .port_clock_en(port_clock_en), .irq(irq)
  );

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic close_out();
    $display("counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one setup cycle, then access phase held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic exp_err, output logic [31:0] r);
    int n;
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      $display("CHECK FAILED pready expected 1 seen timeout");
      close_out();
    end
    r = prdata;
    check("pslverr", {31'h0, pslverr}, {31'h0, exp_err});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'b1, a, d, 1'b0, r);
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    apb(1'b0, a, 32'h0, 1'b0, r);
  endtask

  task automatic gate_is(input logic [4:0] exp);
    repeat (4) @(posedge core_clk);
    #1;
    check("port_clock_en", {27'h0, port_clock_en}, {27'h0, exp});
  endtask

  task automatic irq_is(input logic exp);
    repeat (3) @(posedge core_clk);
    #1;
    check("irq", {31'h0, irq}, {31'h0, exp});
  endtask

  // index 5 names no port, so it faults too
  task automatic faults(input logic [4:0] en);
    for (int i = 0; i < 6; i++) begin
      @(posedge core_clk);
      port_access     <= 1'b1;
      port_access_sel <= 3'(i);
      @(posedge core_clk);
      port_access     <= 1'b0;
      #1;
      check("port_bus_fault", {31'h0, port_bus_fault}, {31'h0, (i > 4) || !en[i]});
    end
  endtask

  initial begin
    n_errors        = 0;
    comparisons     = 0;
    rst             = 1'b1;
    psel            = 1'b0;
    penable         = 1'b0;
    pwrite          = 1'b0;
    paddr           = 12'h000;
    pwdata          = 32'h0;
    sleep_req       = 1'b0;
    deep_sleep_req  = 1'b0;
    port_access     = 1'b0;
    port_access_sel = 3'h0;
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rd(`SG_OFF_SLEEP_GATE, rd_val);
    check("sleep gate reset", rd_val, `SG_GATE_RESET);
    gate_is(5'h00);
    $display("test reset done");
    wr(`SG_OFF_SLEEP_GATE, 32'hffffffff);
    rd(`SG_OFF_SLEEP_GATE, rd_val);
    check("sleep gate all ones", rd_val, 32'h0000001f);
    wr(`SG_OFF_SLEEP_GATE, 32'hffffffe0);
    rd(`SG_OFF_SLEEP_GATE, rd_val);
    check("sleep gate reserved only", rd_val, 32'h00000000);
    $display("test reserved bits done");
    wr(`SG_OFF_RUN_GATE, 32'h05);
    gate_is(5'h05);
    faults(5'h05);
    wr(`SG_OFF_SLEEP_GATE, 32'h1a);
    sleep_req <= 1'b1;
    gate_is(5'h05);
    wr(`SG_OFF_RUN_CFG, 32'h1 << `SG_BIT_AUTO_GATE);
    gate_is(5'h1a);
    faults(5'h1a);
    for (int i = 0; i < 5; i++) begin
      wr(`SG_OFF_SLEEP_GATE, 32'h1 << i);
      gate_is(5'(1 << i));
    end
    wr(`SG_OFF_DEEP_GATE, 32'h03);
    deep_sleep_req <= 1'b1;
    gate_is(5'h03);
    rd(`SG_OFF_POWER_STATE, rd_val);
    check("power state deep", rd_val, 32'h00000043);
    @(posedge core_clk);
    sleep_req      <= 1'b0;
    deep_sleep_req <= 1'b0;
    gate_is(5'h05);
    $display("test mode gating done");
    rd(`SG_OFF_IRQ_STATUS, rd_val);
    check("status after modes", rd_val, 32'h00000007);
    wr(`SG_OFF_IRQ_MASK, 32'h1 << `SG_IRQ_FAULT_BIT);
    irq_is(1'b0);
    faults(5'h05);
    irq_is(1'b1);
    wr(`SG_OFF_IRQ_MASK, 32'h0);
    irq_is(1'b0);
    wr(`SG_OFF_IRQ_MASK, 32'h1 << `SG_IRQ_FAULT_BIT);
    irq_is(1'b1);
    rd(`SG_OFF_IRQ_STATUS, rd_val);
    check("fault status", {31'h0, rd_val[`SG_IRQ_FAULT_BIT]}, 32'h1);
    irq_is(1'b0);
    $display("test interrupt done");
    apb(1'b1, 12'h300, 32'h1f, 1'b1, rd_val);
    apb(1'b0, 12'h300, 32'h0, 1'b1, rd_val);
    rd(`SG_OFF_SLEEP_GATE, rd_val);
    check("sleep gate kept", rd_val, 32'h00000010);
    $display("test unmapped done");
    close_out();
  end
endmodule // sleep_port_clock_gating_tb_top
